// File: design/upc_map.vh
// Address map, field positions, reset values and timing of the uplink port
// interface configuration block. Definitions only; included by bare name.
`ifndef UPC_MAP_VH
`define UPC_MAP_VH

// Register addresses on the 8-bit register port
`define UPC_ADDR_GLOBAL_SPEED 8'h06
`define UPC_ADDR_CAP_P1 8'h17
`define UPC_ADDR_CAP_P2 8'h27
`define UPC_ADDR_CAP_P3 8'h37
`define UPC_ADDR_RSVD_P4 8'h47
`define UPC_ADDR_RSVD_P5 8'h57
`define UPC_ADDR_CFG_P4 8'h46
`define UPC_ADDR_CFG_P5 8'h56
`define UPC_ADDR_STATUS 8'h58

// Global speed register: 1 selects 10 Mbps, 0 selects 100 Mbps
`define UPC_GLOBAL_SPEED_BIT 4
`define UPC_GLOBAL_SPEED_RESET 1'h0

// Capability advertise registers: bits 7-6 read zero
`define UPC_CAP_MASK 8'h3f
`define UPC_CAP_RESET 8'h3f

// Interface configuration field positions
`define UPC_CFG_CLK_SEL 7
`define UPC_CFG_GIGABIT 6
`define UPC_CFG_RSVD 5
`define UPC_CFG_ID_INGRESS 4
`define UPC_CFG_ID_EGRESS 3
`define UPC_CFG_MII_ROLE 2
`define UPC_CFG_MODE_HI 1
`define UPC_CFG_MODE_LO 0

// Interface mode encodings
`define UPC_MODE_MII 2'h0
`define UPC_MODE_RMII 2'h1
`define UPC_MODE_RSVD 2'h2
`define UPC_MODE_RGMII 2'h3

// Reset values of the configuration fields
`define UPC_CFG5_CLK_SEL_RESET 1'h1
`define UPC_CFG4_CLK_SEL_RESET 1'h0
`define UPC_CFG_GIGABIT_RESET 1'h1
`define UPC_CFG_RSVD_VALUE 1'h1
`define UPC_CFG_ID_INGRESS_RESET 1'h0
`define UPC_CFG_ID_EGRESS_RESET 1'h1
`define UPC_CFG_MII_ROLE_RESET 1'h1
`define UPC_CFG_MODE_RESET 2'h3

// Status register field positions
`define UPC_STAT_LINK_ACTIVE 0
`define UPC_STAT_MODE_BAD 1
`define UPC_STAT_STRAPS_DONE 2

// Timing
`define UPC_CLK_MHZ 10
`define UPC_LINK_TIMEOUT_NS 1600
`define UPC_STRAP_SETTLE 2'h2

`endif

// File: design/upc_sync.v
// Two-flop synchroniser for a group of independent single-bit levels.
// Assumes each bit is a slow level or a clock far slower than clk.
`timescale 1ns/1ps
`default_nettype none

module upc_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  genvar i;

  // One pair of flops per bit; the first stage feeds only the second
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_r;
      reg sync_r;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r <= 1'h0;
          sync_r <= 1'h0;
        end else begin
          meta_r <= d[i];
          sync_r <= meta_r;
        end
      end
      assign q[i] = sync_r;
    end
  endgenerate

endmodule

`default_nettype wire

// File: design/upc_top.v
// Uplink port interface configuration: register bank and pin direction control.
// Assumes straps are stable around reset release and the link clock is slow
// enough (800 ns period) to be sampled by ref_clk.
//
// What this block does
// - The gigabit select bit picks 1 Gbps when set and 10/100 Mbps when clear in RGMII mode.
// - The gigabit select bit loads from its strap pin at reset, defaulting to gigabit.
// - In 10/100 operation the 10 or 100 choice follows the global speed bit.
// - The fourth port's copy keeps gigabit, role and mode bits reserved and inert.
// - The ingress delay bit adds receive clock delay when set, on the fifth port only in RGMII mode, and resets to 0.
// - The egress delay bit delays the transmit clock when set, on the fifth port only in RGMII mode, and resets to 1.
// - The role bit makes the MII the MAC side when set, the PHY side when clear.
// - The role bit loads from its strap pin at reset, defaulting to MAC.
// - In MII mode with PHY role the CRS, COL, RXC and TXC pins become driven outputs.
// - The mode field selects MII 00, RMII 01, RGMII 11, with 10 reserved.
// - The mode field loads from two strap pins at reset, defaulting to RGMII.
// - In RMII mode clock select set makes the port drive its 50 MHz reference clock.
`timescale 1ns/1ps
`default_nettype none
`include "upc_map.vh"

module upc_top #(
  parameter CLK_MHZ = `UPC_CLK_MHZ,
  parameter LINK_TIMEOUT_NS = `UPC_LINK_TIMEOUT_NS
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire speed_strap_pin,
  input wire mii_role_strap_pin,
  input wire [1:0] interface_mode_strap_pins,
  input wire uplink_link_clk,
  output reg uplink_mii_mode,
  output reg uplink_rmii_mode,
  output reg uplink_rgmii_mode,
  output reg uplink_rgmii_gigabit,
  output reg uplink_speed_100,
  output reg uplink_rx_delay_en,
  output reg uplink_tx_delay_en,
  output reg uplink_mii_mac_role,
  output reg uplink_crs_oe,
  output reg uplink_col_oe,
  output reg uplink_rxc_oe,
  output reg uplink_txc_oe,
  output reg uplink_refclk_oe,
  output reg port4_refclk_oe,
  output reg port4_rx_delay_en,
  output reg port4_tx_delay_en
);

  // Link clock silence limit in cycles, rounded down, never below one
  localparam TIMEOUT_RAW = (LINK_TIMEOUT_NS * CLK_MHZ) / 1000;
  localparam TIMEOUT_CYC = (TIMEOUT_RAW < 1) ? 1 : TIMEOUT_RAW;
  localparam [7:0] TIMEOUT_LIM = TIMEOUT_CYC[7:0];

  // Strap capture machine, one-hot
  localparam [1:0] ST_SETTLE = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;

  // Synchronised pins
  wire [4:0] pins_s;
  wire speed_strap_s;
  wire role_strap_s;
  wire [1:0] mode_strap_s;
  wire link_clk_s;

  // Strap capture state
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [1:0] settle_r;
  reg [1:0] settle_nxt;
  wire strap_load;

  // Fifth port configuration fields
  reg cfg5_clk_sel_r;
  reg cfg5_gigabit_r;
  reg cfg5_id_in_r;
  reg cfg5_id_eg_r;
  reg cfg5_role_r;
  reg [1:0] cfg5_mode_r;

  // Fourth port configuration fields (only the live bits are stored)
  reg cfg4_clk_sel_r;
  reg cfg4_id_in_r;
  reg cfg4_id_eg_r;

  // Global speed and capability registers
  reg speed10_r;
  reg [7:0] cap_r [0:2];

  // Link clock watch
  reg link_clk_d_r;
  reg [7:0] idle_cnt_r;
  reg link_active_r;
  wire link_edge;

  // Decoded write strobes
  wire wr_cfg5;
  wire wr_cfg4;
  wire wr_speed;

  // Assembled read images
  wire [7:0] cfg5_img;
  wire [7:0] cfg4_img;
  wire [7:0] speed_img;
  wire [7:0] status_img;
  reg [7:0] rdata_nxt;

  // Decoded mode
  wire mode_mii;
  wire mode_rmii;
  wire mode_rgmii;
  wire mode_bad;

  // Straps and link clock pass two flops before use
  upc_sync #(
    .W(5)
  ) u_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d({uplink_link_clk, interface_mode_strap_pins, mii_role_strap_pin, speed_strap_pin}),
    .q(pins_s)
  );

  assign speed_strap_s = pins_s[0];
  assign role_strap_s = pins_s[1];
  assign mode_strap_s = pins_s[3:2];
  assign link_clk_s = pins_s[4];

  // Next state: wait for the synchronisers to fill, then run
  always @* begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    case (state_r)
      ST_SETTLE: begin
        if (settle_r == `UPC_STRAP_SETTLE) begin
          state_nxt = ST_RUN;
        end else begin
          settle_nxt = settle_r + 2'h1;
        end
      end
      ST_RUN: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_SETTLE;
        settle_nxt = 2'h0;
      end
    endcase
  end

  // Strap capture registers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_SETTLE;
      settle_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      settle_r <= settle_nxt;
    end
  end

  // One-cycle pulse when the synchronised straps are valid
  assign strap_load = (state_r == ST_SETTLE) && (settle_r == `UPC_STRAP_SETTLE);

  // Write decode
  assign wr_cfg5 = reg_wr && (reg_addr == `UPC_ADDR_CFG_P5);
  assign wr_cfg4 = reg_wr && (reg_addr == `UPC_ADDR_CFG_P4);
  assign wr_speed = reg_wr && (reg_addr == `UPC_ADDR_GLOBAL_SPEED);

  // Fifth port configuration; a write in the capture cycle beats the straps
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg5_clk_sel_r <= `UPC_CFG5_CLK_SEL_RESET;
      cfg5_gigabit_r <= `UPC_CFG_GIGABIT_RESET;
      cfg5_id_in_r <= `UPC_CFG_ID_INGRESS_RESET;
      cfg5_id_eg_r <= `UPC_CFG_ID_EGRESS_RESET;
      cfg5_role_r <= `UPC_CFG_MII_ROLE_RESET;
      cfg5_mode_r <= `UPC_CFG_MODE_RESET;
    end else if (wr_cfg5) begin
      cfg5_clk_sel_r <= reg_wdata[`UPC_CFG_CLK_SEL];
      cfg5_gigabit_r <= reg_wdata[`UPC_CFG_GIGABIT];
      cfg5_id_in_r <= reg_wdata[`UPC_CFG_ID_INGRESS];
      cfg5_id_eg_r <= reg_wdata[`UPC_CFG_ID_EGRESS];
      cfg5_role_r <= reg_wdata[`UPC_CFG_MII_ROLE];
      cfg5_mode_r <= reg_wdata[`UPC_CFG_MODE_HI:`UPC_CFG_MODE_LO];
    end else if (strap_load) begin
      cfg5_gigabit_r <= speed_strap_s;
      cfg5_role_r <= role_strap_s;
      cfg5_clk_sel_r <= role_strap_s; // Shares the role strap
      cfg5_mode_r <= mode_strap_s;
    end
  end

  // Fourth port copy: gigabit, role and mode bits are not stored
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg4_clk_sel_r <= `UPC_CFG4_CLK_SEL_RESET;
      cfg4_id_in_r <= `UPC_CFG_ID_INGRESS_RESET;
      cfg4_id_eg_r <= `UPC_CFG_ID_EGRESS_RESET;
    end else if (wr_cfg4) begin
      cfg4_clk_sel_r <= reg_wdata[`UPC_CFG_CLK_SEL];
      cfg4_id_in_r <= reg_wdata[`UPC_CFG_ID_INGRESS];
      cfg4_id_eg_r <= reg_wdata[`UPC_CFG_ID_EGRESS];
    end
  end

  // Global speed bit
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      speed10_r <= `UPC_GLOBAL_SPEED_RESET;
    end else if (wr_speed) begin
      speed10_r <= reg_wdata[`UPC_GLOBAL_SPEED_BIT];
    end
  end

  // Capability advertise registers of ports one to three
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_cap
      wire [7:0] cap_addr;
      assign cap_addr = (gi == 0) ? `UPC_ADDR_CAP_P1 :
                        (gi == 1) ? `UPC_ADDR_CAP_P2 : `UPC_ADDR_CAP_P3;
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          cap_r[gi] <= `UPC_CAP_RESET;
        end else if (reg_wr && (reg_addr == cap_addr)) begin
          cap_r[gi] <= reg_wdata & `UPC_CAP_MASK;
        end
      end
    end
  endgenerate

  // Link clock edge finder on the second synchroniser stage
  assign link_edge = link_clk_s && !link_clk_d_r;

  // Link clock activity: rising edges restart the silence counter
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_clk_d_r <= 1'h0;
      idle_cnt_r <= 8'h00;
      link_active_r <= 1'h0;
    end else begin
      link_clk_d_r <= link_clk_s;
      if (link_edge) begin
        idle_cnt_r <= 8'h00;
        link_active_r <= 1'h1;
      end else if (idle_cnt_r >= TIMEOUT_LIM) begin
        link_active_r <= 1'h0;
      end else begin
        idle_cnt_r <= idle_cnt_r + 8'h01;
      end
    end
  end

  // Mode decode of the fifth port
  assign mode_mii = (cfg5_mode_r == `UPC_MODE_MII);
  assign mode_rmii = (cfg5_mode_r == `UPC_MODE_RMII);
  assign mode_rgmii = (cfg5_mode_r == `UPC_MODE_RGMII);
  assign mode_bad = (cfg5_mode_r == `UPC_MODE_RSVD);

  // Read images; the reserved bit always reads back its fixed value
  assign cfg5_img = {cfg5_clk_sel_r, cfg5_gigabit_r, `UPC_CFG_RSVD_VALUE, cfg5_id_in_r,
                     cfg5_id_eg_r, cfg5_role_r, cfg5_mode_r};
  assign cfg4_img = {cfg4_clk_sel_r, 1'h0, `UPC_CFG_RSVD_VALUE, cfg4_id_in_r,
                     cfg4_id_eg_r, 3'h0};
  assign speed_img = {3'h0, speed10_r, 4'h0};
  assign status_img = {5'h00, (state_r == ST_RUN), mode_bad, link_active_r};

  // Read mux; unmapped and reserved addresses read zero
  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      `UPC_ADDR_CFG_P5: rdata_nxt = cfg5_img;
      `UPC_ADDR_CFG_P4: rdata_nxt = cfg4_img;
      `UPC_ADDR_GLOBAL_SPEED: rdata_nxt = speed_img;
      `UPC_ADDR_CAP_P1: rdata_nxt = cap_r[0];
      `UPC_ADDR_CAP_P2: rdata_nxt = cap_r[1];
      `UPC_ADDR_CAP_P3: rdata_nxt = cap_r[2];
      `UPC_ADDR_STATUS: rdata_nxt = status_img;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Fifth port mode and speed outputs
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      uplink_mii_mode <= 1'h0;
      uplink_rmii_mode <= 1'h0;
      uplink_rgmii_mode <= 1'h0;
      uplink_rgmii_gigabit <= 1'h0;
      uplink_speed_100 <= 1'h0;
      uplink_rx_delay_en <= 1'h0;
      uplink_tx_delay_en <= 1'h0;
      uplink_mii_mac_role <= 1'h0;
    end else begin
      uplink_mii_mode <= mode_mii;
      uplink_rmii_mode <= mode_rmii;
      uplink_rgmii_mode <= mode_rgmii;
      uplink_rgmii_gigabit <= mode_rgmii && cfg5_gigabit_r;
      uplink_speed_100 <= !(mode_rgmii && cfg5_gigabit_r) && !speed10_r;
      uplink_rx_delay_en <= mode_rgmii && cfg5_id_in_r;
      uplink_tx_delay_en <= mode_rgmii && cfg5_id_eg_r;
      uplink_mii_mac_role <= cfg5_role_r;
    end
  end

  // Pin directions: MII mode in PHY role drives CRS, COL, RXC, TXC; RMII clock mode drives refclk
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      uplink_crs_oe <= 1'h0;
      uplink_col_oe <= 1'h0;
      uplink_rxc_oe <= 1'h0;
      uplink_txc_oe <= 1'h0;
      uplink_refclk_oe <= 1'h0;
    end else begin
      uplink_crs_oe <= mode_mii && !cfg5_role_r;
      uplink_col_oe <= mode_mii && !cfg5_role_r;
      uplink_rxc_oe <= mode_mii && !cfg5_role_r;
      uplink_txc_oe <= mode_mii && !cfg5_role_r;
      uplink_refclk_oe <= mode_rmii && cfg5_clk_sel_r;
    end
  end

  // Fourth port outputs: only clock select and delays act
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port4_refclk_oe <= 1'h0;
      port4_rx_delay_en <= 1'h0;
      port4_tx_delay_en <= 1'h0;
    end else begin
      port4_refclk_oe <= cfg4_clk_sel_r;
      port4_rx_delay_en <= cfg4_id_in_r;
      port4_tx_delay_en <= cfg4_id_eg_r;
    end
  end

endmodule

`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the uplink interface configuration block.
// Assumes upc_top, upc_partner and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic link_run = 1'b0;
  logic [3:0] pull_dn = 4'h0;
  wire [7:0] reg_rdata;
  wire link_clk;
  wire spd_pin;
  wire role_pin;
  wire [1:0] mode_pins;
  wire [12:0] outs;
  wire [2:0] p4;
  int fails = 0;
  int checked = 0;
  logic [7:0] cfgs [6] = '{8'h3b, 8'hf9, 8'h21, 8'h20, 8'h24, 8'he7};
  logic [3:0] pds [3] = '{4'h0, 4'hf, 4'h2};
  logic [7:0] rcfg [3] = '{8'hef, 8'h28, 8'hed};

  // 10 MHz reference clock
  always #50 ref_clk = ~ref_clk;

  upc_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .speed_strap_pin(spd_pin), .mii_role_strap_pin(role_pin),
    .interface_mode_strap_pins(mode_pins), .uplink_link_clk(link_clk),
    .uplink_mii_mode(outs[12]), .uplink_rmii_mode(outs[11]),
    .uplink_rgmii_mode(outs[10]), .uplink_rgmii_gigabit(outs[9]),
    .uplink_speed_100(outs[8]), .uplink_rx_delay_en(outs[7]),
    .uplink_tx_delay_en(outs[6]), .uplink_mii_mac_role(outs[5]),
    .uplink_crs_oe(outs[4]), .uplink_col_oe(outs[3]), .uplink_rxc_oe(outs[2]),
    .uplink_txc_oe(outs[1]), .uplink_refclk_oe(outs[0]), .port4_refclk_oe(p4[2]),
    .port4_rx_delay_en(p4[1]), .port4_tx_delay_en(p4[0]));

  upc_partner far_end (.run(link_run), .pull_dn(pull_dn), .link_clk(link_clk),
    .speed_strap_pin(spd_pin), .mii_role_strap_pin(role_pin),
    .interface_mode_strap_pins(mode_pins));

  // Expected uplink outputs from a config image and the global speed bit
  function automatic logic [12:0] exp_out(input logic [7:0] c, input logic g);
    logic mii, rmii, rg, gig;
    mii = c[1:0] == 2'h0;
    rmii = c[1:0] == 2'h1;
    rg = c[1:0] == 2'h3;
    gig = rg & c[6];
    return {mii, rmii, rg, gig, ~gig & ~g, rg & c[4], rg & c[3], c[2],
      {4{mii & ~c[2]}}, rmii & c[7]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (fails == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Register port: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    check(v, e);
  endtask

  // Outputs follow a taken write one edge later
  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic do_reset(input logic [3:0] pd);
    @(posedge ref_clk);
    pull_dn <= pd;
    rst_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask

  // Poll the status register under a bounded count
  task automatic wait_stat(input logic [7:0] e);
    logic [7:0] v;
    int n;
    n = 0;
    rd(8'h58, v);
    while (v !== e && n < 40) begin
      rd(8'h58, v);
      n++;
    end
    check(v, e);
    if (v !== e) final_report();
  endtask

  initial begin
    // Strap combinations loaded at reset, the last ones in mid-run
    for (int i = 0; i < 3; i++) begin
      do_reset(pds[i]);
      rdchk(8'h56, rcfg[i]);
      check(outs, exp_out(rcfg[i], 1'b0));
    end
    rdchk(8'h46, 8'h28);
    // Six mode, role, speed and delay mixes under both global speeds
    for (int g = 0; g < 2; g++) begin
      wr(8'h06, {3'h0, g[0], 4'h0});
      rdchk(8'h06, {3'h0, g[0], 4'h0});
      for (int i = 0; i < 6; i++) begin
        wr(8'h56, cfgs[i]);
        settle();
        check(outs, exp_out(cfgs[i], g[0]));
        rdchk(8'h56, cfgs[i]);
      end
    end
    // Fourth port copy: only clock select and delays take effect
    wr(8'h46, 8'hff);
    settle();
    check(outs, exp_out(8'he7, 1'b1));
    check(p4, 3'h7);
    rdchk(8'h46, 8'hb8);
    wr(8'h46, 8'h00);
    settle();
    check(p4, 3'h0);
    rdchk(8'h46, 8'h20);
    // Reserved slots ignore writes; capability keeps bits 5-0 only
    wr(8'h47, 8'hff);
    wr(8'h57, 8'hff);
    wr(8'h17, 8'hff);
    rdchk(8'h47, 8'h00);
    rdchk(8'h57, 8'h00);
    rdchk(8'h17, 8'h3f);
    // Link clock activity seen, then lost after it stops
    link_run <= 1'b1;
    wait_stat(8'h05);
    link_run <= 1'b0;
    wait_stat(8'h04);
    // Reserved mode code from the straps, reset again in mid-run
    do_reset(4'h1);
    rdchk(8'h56, 8'hee);
    check(outs, exp_out(8'hee, 1'b0));
    rdchk(8'h58, 8'h06);
    final_report();
  end
endmodule
`default_nettype wire

// File: sim/upc_partner.sv
// Board model at the uplink: strap resistors and the far side's link clock.
// Assumes the bench drives run and pull_dn; straps float high unless pulled.
`timescale 1ns/1ps
`default_nettype none
module upc_partner (
  input wire logic run,
  input wire logic [3:0] pull_dn,
  output logic link_clk,
  output wire logic speed_strap_pin,
  output wire logic mii_role_strap_pin,
  output wire logic [1:0] interface_mode_strap_pins
);
  // Internal pull-ups win unless the board pulls a strap down
  assign speed_strap_pin = ~pull_dn[3];
  assign mii_role_strap_pin = ~pull_dn[2];
  assign interface_mode_strap_pins = ~pull_dn[1:0];
  // 800 ns link clock, offset in phase, parked low while idle
  initial begin
    link_clk = 1'b0;
    #137;
    forever begin
      #400;
      link_clk = run ? ~link_clk : 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: sim/upc_properties.sv
// Checker for the uplink interface configuration outputs.
// Assumes it is bound to upc_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module upc_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic uplink_mii_mode,
  input wire logic uplink_rmii_mode,
  input wire logic uplink_rgmii_mode,
  input wire logic uplink_rgmii_gigabit,
  input wire logic uplink_speed_100,
  input wire logic uplink_rx_delay_en,
  input wire logic uplink_tx_delay_en,
  input wire logic uplink_mii_mac_role,
  input wire logic uplink_crs_oe,
  input wire logic uplink_col_oe,
  input wire logic uplink_rxc_oe,
  input wire logic uplink_txc_oe,
  input wire logic uplink_refclk_oe,
  input wire logic port4_tx_delay_en
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // Mode decode and the settings that depend on it
  AST_MODE_ONEHOT: assert property (
    $onehot0({uplink_mii_mode, uplink_rmii_mode, uplink_rgmii_mode}))
    else $error("mode outputs overlap");
  AST_GIG_RGMII: assert property (uplink_rgmii_gigabit |-> uplink_rgmii_mode)
    else $error("gigabit outside rgmii");
  AST_SPEED_SEL: assert property (uplink_rgmii_gigabit |-> !uplink_speed_100)
    else $error("100 mbps while gigabit");
  AST_RX_DELAY: assert property (uplink_rx_delay_en |-> uplink_rgmii_mode)
    else $error("rx delay outside rgmii");
  AST_TX_DELAY: assert property (uplink_tx_delay_en |-> uplink_rgmii_mode)
    else $error("tx delay outside rgmii");
  AST_PHY_OE: assert property (
    {uplink_crs_oe, uplink_col_oe, uplink_rxc_oe, uplink_txc_oe} ==
    {4{uplink_mii_mode && !uplink_mii_mac_role}})
    else $error("phy pin drive mismatch");
  AST_REFCLK: assert property (uplink_refclk_oe |-> uplink_rmii_mode)
    else $error("refclk driven outside rmii");
  // Writes reach the outputs one edge after they are taken, seen by the checks at the second
  AST_WR_RGMII: assert property (
    reg_wr && reg_addr == 8'h56 && reg_wdata[1:0] == 2'h3 |-> ##2 uplink_rgmii_mode)
    else $error("rgmii write not applied");
  AST_WR_RMII: assert property (
    reg_wr && reg_addr == 8'h56 && reg_wdata[1:0] == 2'h1 |-> ##2 uplink_rmii_mode)
    else $error("rmii write not applied");
  AST_P4_TXD: assert property (
    reg_wr && reg_addr == 8'h46 |-> ##2 port4_tx_delay_en == $past(reg_wdata[3], 2))
    else $error("fourth port egress bit not applied");
  AST_RSVD_BIT: assert property (reg_rd && reg_addr == 8'h56 |=> reg_rdata[5])
    else $error("reserved bit read low");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
endmodule
bind upc_top upc_props u_props (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .uplink_mii_mode(uplink_mii_mode), .uplink_rmii_mode(uplink_rmii_mode),
  .uplink_rgmii_mode(uplink_rgmii_mode), .uplink_rgmii_gigabit(uplink_rgmii_gigabit),
  .uplink_speed_100(uplink_speed_100), .uplink_rx_delay_en(uplink_rx_delay_en),
  .uplink_tx_delay_en(uplink_tx_delay_en), .uplink_mii_mac_role(uplink_mii_mac_role),
  .uplink_crs_oe(uplink_crs_oe), .uplink_col_oe(uplink_col_oe),
  .uplink_rxc_oe(uplink_rxc_oe), .uplink_txc_oe(uplink_txc_oe),
  .uplink_refclk_oe(uplink_refclk_oe), .port4_tx_delay_en(port4_tx_delay_en));
`default_nettype wire
